// [rtl/dcc_top.sv]
// DMA checksum generator with per-channel cell size and progress.
// Assumes an AHB-Lite master on clk and a DMA byte stream on clk.
`timescale 1ns/10ps
`default_nettype none
module dcc_top #(
  parameter int CHANNELS = 4,
  parameter int DEPTH = dcc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output var logic [31:0] hrdata,
  output var logic hreadyout,
  output var logic hresp,
  input wire logic byteValid,
  output var logic byteReady,
  input wire logic [7:0] byteData,
  input wire logic [dcc_pkg::CHAN_W-1:0] byteChannel,
  input wire logic [CHANNELS-1:0] patternMode,
  input wire logic [CHANNELS-1:0] patternMatch,
  output var logic [CHANNELS-1:0] cellDone
);
  localparam int FW = 8 + dcc_pkg::CHAN_W;

  function automatic logic [31:0] lenMask(logic [4:0] len);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 32; i++)
      m[i] = (5'(i) <= len);
    return m;
  endfunction

  // Byte enters MSB first; tap bit i set XORs feedback into stage i
  function automatic logic [31:0] lfsrByte(logic [31:0] s, logic [7:0] d,
                                           logic [31:0] taps,
                                           logic [4:0] len);
    logic [31:0] r;
    logic fb;
    r = s;
    for (int b = 7; b >= 0; b--)
    begin
      fb = d[b] ^ r[len];
      r = {r[30:0], fb} ^ ({taps[31:1], 1'b0} & {32{fb}});
    end
    return r & lenMask(len);
  endfunction

  function automatic logic [15:0] onesAdd(logic [15:0] a, logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[15:0] + {15'h0000, t[16]};
  endfunction

  logic [31:0] controlReg;
  logic [31:0] feedbackReg;
  logic [31:0] crcStateReg;
  logic [15:0] ipSumReg;
  logic [7:0] ipHighReg;
  dcc_pkg::dcc_half_type halfReg;
  logic [15:0] cellSizeReg [CHANNELS];
  logic [15:0] progressReg [CHANNELS];
  logic wrPendReg;
  logic [7:0] wrAddrReg;

  logic ipMode;
  logic crcOn;
  logic [4:0] polyLen;
  logic [dcc_pkg::CHAN_W-1:0] crcChan;
  assign ipMode = controlReg[dcc_pkg::TYPE_BIT];
  assign crcOn = controlReg[dcc_pkg::ENABLE_BIT];
  assign polyLen = controlReg[dcc_pkg::LEN_W-1:0];
  assign crcChan = controlReg[dcc_pkg::CHAN_LSB +: dcc_pkg::CHAN_W];

  // Bus decode
  logic addrPhase;
  logic [7:0] aOfs;
  assign addrPhase = hsel && hready && htrans == dcc_pkg::TRANS_NONSEQ;
  assign aOfs = haddr[7:0];

  function automatic logic isCell(logic [7:0] a, int ch, logic [7:0] sub);
    return a == dcc_pkg::CELL_BASE_OFS + 8'(ch) * dcc_pkg::CELL_STRIDE + sub;
  endfunction

  logic valueWrite;
  logic feedbackWrite;
  assign valueWrite = wrPendReg && wrAddrReg == dcc_pkg::VALUE_OFS;
  assign feedbackWrite = wrPendReg && wrAddrReg == dcc_pkg::FEEDBACK_OFS;

  logic [31:0] valueRead;
  assign valueRead = ipMode ? {16'h0000, ~ipSumReg}
                            : crcStateReg & lenMask(polyLen);

  logic [31:0] readMux;
  always_comb
  begin
    readMux = dcc_pkg::ZERO_WORD;
    if (aOfs == dcc_pkg::CONTROL_OFS)
      readMux = controlReg;
    else if (aOfs == dcc_pkg::VALUE_OFS)
      readMux = valueRead;
    else if (aOfs == dcc_pkg::FEEDBACK_OFS)
      readMux = feedbackReg;
    for (int c = 0; c < CHANNELS; c++)
    begin
      if (isCell(aOfs, c, 8'h00))
        readMux = {16'h0000, cellSizeReg[c]};
      if (isCell(aOfs, c, dcc_pkg::PROGRESS_OFS))
        readMux = {16'h0000, progressReg[c]};
    end
  end

  // Zero wait states: read data is latched at the address phase edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hrdata <= dcc_pkg::ZERO_WORD;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPendReg <= 1'b0;
      wrAddrReg <= '0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPendReg <= addrPhase && hwrite;
      if (addrPhase)
        wrAddrReg <= aOfs;
      if (addrPhase && !hwrite)
        hrdata <= readMux;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      controlReg <= dcc_pkg::ZERO_WORD;
      feedbackReg <= dcc_pkg::ZERO_WORD;
    end
    else
    begin
      if (wrPendReg && wrAddrReg == dcc_pkg::CONTROL_OFS)
        controlReg <= hwdata & dcc_pkg::CONTROL_MASK;
      if (feedbackWrite)
        feedbackReg <= hwdata;
    end
  end

  // Byte stream: cell accounting on every accepted byte of a channel below CHANNELS, checksum bytes
  // go through the FIFO. The FIFO's ready stalls the whole stream.
  logic fifoInReady;
  logic fifoOutValid;
  logic [FW-1:0] fifoOut;
  logic engineReady;
  logic byteTake;
  logic crcByte;
  assign byteTake = byteValid && byteReady;
  assign crcByte = crcOn && byteChannel == crcChan;
  assign byteReady = fifoInReady;
  // A seed write in flight stalls the drain so it is never overwritten
  assign engineReady = !valueWrite;

  dcc_fifo #(
    .WIDTH(FW),
    .DEPTH(DEPTH)
  ) dataFifo (
    .clk(clk),
    .rst(rst),
    .inValid(byteValid && crcByte),
    .inReady(fifoInReady),
    .inData({byteChannel, byteData}),
    .outValid(fifoOutValid),
    .outReady(engineReady),
    .outData(fifoOut)
  );

  logic consume;
  logic [7:0] eByte;
  assign consume = fifoOutValid && engineReady;
  assign eByte = fifoOut[7:0];

  always_ff @(posedge clk)
  begin
    if (rst)
      crcStateReg <= dcc_pkg::ZERO_WORD;
    else if (valueWrite && !ipMode)
      crcStateReg <= hwdata & lenMask(polyLen);
    else if (consume && !ipMode)
      crcStateReg <= lfsrByte(crcStateReg, eByte, feedbackReg,
                              polyLen);
  end

  // Header sum: bytes pair high then low; an odd byte waits for its mate
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ipSumReg <= 16'h0000;
      ipHighReg <= 8'h00;
      halfReg <= dcc_pkg::HALF_HIGH;
    end
    else if (valueWrite && ipMode)
    begin
      ipSumReg <= ~hwdata[dcc_pkg::HALF_W-1:0];
      halfReg <= dcc_pkg::HALF_HIGH;
    end
    else if (consume && ipMode)
    begin
      unique case (halfReg)
        dcc_pkg::HALF_HIGH:
        begin
          ipHighReg <= eByte;
          halfReg <= dcc_pkg::HALF_LOW;
        end
        dcc_pkg::HALF_LOW:
        begin
          ipSumReg <= onesAdd(ipSumReg, {ipHighReg, eByte});
          halfReg <= dcc_pkg::HALF_HIGH;
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : chan
      logic hit;
      logic last;
      assign hit = byteTake && byteChannel == dcc_pkg::CHAN_W'(g);
      assign last = progressReg[g] + dcc_pkg::CELL_ONE == cellSizeReg[g];
      always_ff @(posedge clk)
      begin
        if (rst)
          cellSizeReg[g] <= 16'h0000;
        else if (wrPendReg && isCell(wrAddrReg, g, 8'h00))
          cellSizeReg[g] <= hwdata[dcc_pkg::HALF_W-1:0];
      end
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          progressReg[g] <= 16'h0000;
          cellDone[g] <= 1'b0;
        end
        else
        begin
          cellDone[g] <= hit && last;
          if (patternMode[g] && patternMatch[g])
            progressReg[g] <= 16'h0000;
          else if (hit && last)
            progressReg[g] <= 16'h0000;
          else if (hit)
            progressReg[g] <= progressReg[g] + dcc_pkg::CELL_ONE;
        end
      end

      // Checked per channel so every channel's cell logic is watched
      size_load_a: assert property (@(posedge clk) disable iff (rst)
        wrPendReg && isCell(wrAddrReg, g, 8'h00)
        |=> cellSizeReg[g] == $past(hwdata[dcc_pkg::HALF_W-1:0]))
        else $error("cell size not loaded");

      match_clear_a: assert property (@(posedge clk) disable iff (rst)
        patternMode[g] && patternMatch[g] |=> progressReg[g] == 16'h0000)
        else $error("pattern match did not clear");

      cell_done_a: assert property (@(posedge clk) disable iff (rst)
        hit && last |=> cellDone[g])
        else $error("cell end not flagged");

      cell_wrap_a: assert property (@(posedge clk) disable iff (rst)
        cellDone[g] |-> progressReg[g] == 16'h0000)
        else $error("progress not wrapped");

      progress_ro_a: assert property (@(posedge clk) disable iff (rst)
        wrPendReg && isCell(wrAddrReg, g, dcc_pkg::PROGRESS_OFS) && !hit
        && !(patternMode[g] && patternMatch[g]) |=> $stable(progressReg[g]))
        else $error("progress changed by a write");
    end
  endgenerate

  logic [31:0] valueSeen;
  assign valueSeen = valueRead;

  sequence valueWrPhase;
    wrPendReg && wrAddrReg == dcc_pkg::VALUE_OFS;
  endsequence

  sequence valueRdAddr;
    addrPhase && !hwrite && aOfs == dcc_pkg::VALUE_OFS;
  endsequence

  seed_load_a: assert property (@(posedge clk) disable iff (rst)
    valueWrPhase ##0 !ipMode ##1 $stable(polyLen)
    |-> crcStateReg == ($past(hwdata) & lenMask(polyLen)))
    else $error("seed write not loaded");

  read_value_a: assert property (@(posedge clk) disable iff (rst)
    valueRdAddr |=> hrdata == $past(valueSeen))
    else $error("value read wrong");

  len_zero_a: assert property (@(posedge clk) disable iff (rst)
    valueRdAddr ##0 !ipMode
    |=> (hrdata & ~lenMask($past(polyLen))) == dcc_pkg::ZERO_WORD)
    else $error("bits above length not zero");

  ip_upper_a: assert property (@(posedge clk) disable iff (rst)
    valueRdAddr ##0 ipMode |=> hrdata[31:16] == 16'h0000)
    else $error("header mode upper half set");

  ip_convert_a: assert property (@(posedge clk) disable iff (rst)
    valueWrPhase ##0 ipMode |=> valueSeen[15:0] == $past(hwdata[15:0]))
    else $error("header write not echoed");

  ip_noxor_a: assert property (@(posedge clk) disable iff (rst)
    feedbackWrite && ipMode && !consume && !valueWrite
    |=> $stable(ipSumReg))
    else $error("feedback write disturbed sum");

  lfsr_step_a: assert property (@(posedge clk) disable iff (rst)
    consume && !ipMode |=> crcStateReg == lfsrByte($past(crcStateReg),
      $past(eByte), $past(feedbackReg), $past(polyLen)))
    else $error("shift step wrong");

  size_upper_a: assert property (@(posedge clk) disable iff (rst)
    addrPhase && !hwrite && isCell(aOfs, 0, 8'h00)
    |=> hrdata[31:16] == 16'h0000)
    else $error("cell size upper half set");

  byte_drain_a: assert property (@(posedge clk) disable iff (rst)
    byteTake && crcByte |=> fifoOutValid)
    else $error("checksum byte not queued");

  pair_hold_a: assert property (@(posedge clk) disable iff (rst)
    consume && ipMode && halfReg == dcc_pkg::HALF_HIGH |=> $stable(ipSumReg))
    else $error("odd header byte changed sum");
endmodule
`default_nettype wire

// [rtl/dcc_pkg.sv]
// Constants shared by the DMA checksum and cell counter block.
// Assumes one 100 MHz clock and an AHB-Lite register bus.
// How it works
// - A checksum value write seeds the generator, replacing its state.
// - A checksum value read returns present state without disturbing it.
// - In shift mode, result bits above the polynomial length read zero.
// - In header mode only low 16 bits carry checksum; high half reads zero.
// - In header mode writes are converted; reads give ones-complement sum.
// - In header mode the feedback enable register does not affect checksum.
// - In shift mode a set enable bit XORs feedback into its stage.
// - In shift mode a clear enable bit passes previous stage straight on.
// - Cell byte count sets bytes per trigger; all ones means 65,535.
// - Upper 16 bits of cell size and progress read zero, ignore writes.
// - In pattern-detect mode a pattern match clears the cell progress.
package dcc_pkg;
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] VALUE_OFS = 8'h04;
  localparam logic [7:0] FEEDBACK_OFS = 8'h08;
  localparam logic [7:0] CELL_BASE_OFS = 8'h10;
  localparam logic [7:0] CELL_STRIDE = 8'h08;
  localparam logic [7:0] PROGRESS_OFS = 8'h04;
  localparam int TYPE_BIT = 15;
  localparam int ENABLE_BIT = 7;
  localparam int CHAN_LSB = 8;
  localparam int CHAN_W = 3;
  localparam int LEN_W = 5;
  localparam int HALF_W = 16;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_87DF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [15:0] CELL_ONE = 16'h0001;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic {HALF_HIGH, HALF_LOW} dcc_half_type;
endpackage

// [rtl/dcc_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes both sides run on the one system clock.
`timescale 1ns/10ps
`default_nettype none
module dcc_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output var logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output var logic outValid,
  input wire logic outReady,
  output var logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] memReg [DEPTH];
  logic [AW-1:0] wrPtrReg;
  logic [AW-1:0] rdPtrReg;
  logic [AW:0] countReg;
  logic [AW:0] countNext;
  logic push;
  logic pop;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = memReg[rdPtrReg];
  always_comb
  begin
    countNext = countReg;
    if (push && !pop)
      countNext = countReg + 1'b1;
    else if (pop && !push)
      countNext = countReg - 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (push)
      memReg[wrPtrReg] <= inData;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
    end
    else
    begin
      if (push)
        wrPtrReg <= (wrPtrReg == AW'(DEPTH - 1)) ? '0 : wrPtrReg + 1'b1;
      if (pop)
        rdPtrReg <= (rdPtrReg == AW'(DEPTH - 1)) ? '0 : rdPtrReg + 1'b1;
    end
  end
  // Flags are registered so the ready seen upstream is a clean flop
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      countReg <= '0;
      inReady <= 1'b0;
      outValid <= 1'b0;
    end
    else
    begin
      countReg <= countNext;
      inReady <= countNext != (AW+1)'(DEPTH);
      outValid <= countNext != '0;
    end
  end
endmodule
`default_nettype wire

// [test/dcc_top_tb.sv]
// Self-checking bench for the DMA checksum and cell counter block.
// Assumes a zero-wait AHB-Lite slave and one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module dcc_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic byteValid = 1'b0;
  logic byteReady;
  logic [7:0] byteData = 8'h00;
  logic [dcc_pkg::CHAN_W-1:0] byteChannel = '0;
  logic [3:0] patternMode = 4'h0;
  logic [3:0] patternMatch = 4'h0;
  logic [3:0] cellDone;
  logic [31:0] rd;
  logic [31:0] tap;
  int errTotal = 0;
  int nTests = 0;
  int cycles = 0;
  int donePulses = 0;

  always #5 clk = ~clk;

  dcc_top #(.CHANNELS(4), .DEPTH(16)) dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .byteValid(byteValid), .byteReady(byteReady),
    .byteData(byteData), .byteChannel(byteChannel),
    .patternMode(patternMode), .patternMatch(patternMatch),
    .cellDone(cellDone)
  );

  task automatic completeRun();
    $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A hang ends the run well past the roughly 150 cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cellDone[1] === 1'b1)
      donePulses++;
    if (cycles > 5000)
    begin
      errTotal++;
      completeRun();
    end
  end

  task automatic check(input string what, input logic [31:0] want,
    input logic [31:0] got);
    nTests++;
    if (got !== want)
    begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", what, want, got);
    end
  endtask

  task automatic busXfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= dcc_pkg::TRANS_NONSEQ;
    hwrite <= wr;
    hsize <= dcc_pkg::SIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic busWrite(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    busXfer(1'b1, a, d, unused);
  endtask

  task automatic readCheck(input string what, input logic [7:0] a,
    input logic [31:0] want);
    busXfer(1'b0, a, 32'h0000_0000, rd);
    check(what, want, rd);
  endtask

  // Holds valid across bytes so a burst goes out one per cycle
  task automatic sendBytes(input logic [2:0] ch, input logic [7:0] first,
    input int n);
    byteChannel <= ch;
    byteValid <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      byteData <= first + 8'(i);
      do @(posedge clk); while (byteReady !== 1'b1);
    end
    byteValid <= 1'b0;
  endtask

  // Bitwise shift model, most significant data bit first
  function automatic logic [31:0] lfsr(input logic [31:0] s,
    input logic [7:0] d, input logic [31:0] taps, input int polynomial_length);
    logic fb;
    logic [31:0] st;
    st = s;
    for (int i = 7; i >= 0; i--)
    begin
      fb = d[i] ^ st[polynomial_length];
      st = (st << 1) | {31'h0000_0000, fb};
      if (fb)
        st = st ^ (taps & 32'hFFFF_FFFE);
      st = st & (32'hFFFF_FFFF >> (31 - polynomial_length));
    end
    return st;
  endfunction

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    busWrite(8'hFC, 32'hFFFF_FFFF);
    readCheck("reset control", 8'h00, 32'h0000_0000);
    check("okay response", 32'h0000_0000, 32'(hresp));
    readCheck("reset value", 8'h04, 32'h0000_0000);
    readCheck("reset feedback", 8'h08, 32'h0000_0000);
    readCheck("reset size", 8'h10, 32'h0000_0000);
    readCheck("reset progress", 8'h14, 32'h0000_0000);
    readCheck("unmapped", 8'hFC, 32'h0000_0000);
    $display("test reset done");

    busWrite(8'h00, 32'h0000_0087);
    busWrite(8'h04, 32'hFFFF_FFA5);
    readCheck("seed masked", 8'h04, 32'h0000_00A5);
    readCheck("seed reread", 8'h04, 32'h0000_00A5);
    for (int t = 0; t < 2; t++)
    begin
      tap = (t == 0) ? 32'h0000_0007 : 32'h0000_0000;
      busWrite(8'h08, tap);
      readCheck("feedback", 8'h08, tap);
      busWrite(8'h04, 32'h0000_0000);
      sendBytes(3'h0, 8'h31, 1);
      repeat (4) @(posedge clk);
      readCheck("shift sum", 8'h04,
        lfsr(32'h0, 8'h31, tap, 7));
    end
    $display("test shift mode done");

    busWrite(8'h00, 32'h0000_8080);
    busWrite(8'h08, 32'h0000_FFFF);
    busWrite(8'h04, 32'hABCD_1234);
    readCheck("header echo", 8'h04, 32'h0000_1234);
    sendBytes(3'h0, 8'h00, 2);
    repeat (4) @(posedge clk);
    // Complement of (EDCB + 0001) with end-around carry
    readCheck("header sum", 8'h04, 32'h0000_1233);
    $display("test header mode done");

    busWrite(8'h18, 32'hFFFF_FFFF);
    readCheck("size all ones", 8'h18, 32'h0000_FFFF);
    busWrite(8'h18, 32'h0000_0003);
    busWrite(8'h1C, 32'h0000_FFFF);
    sendBytes(3'h1, 8'h10, 2);
    repeat (2) @(posedge clk);
    readCheck("progress", 8'h1C, 32'h0000_0002);
    check("no early done", 32'h0000_0000, 32'(donePulses));
    sendBytes(3'h1, 8'h12, 1);
    repeat (3) @(posedge clk);
    readCheck("progress wrap", 8'h1C, 32'h0000_0000);
    check("done pulses", 32'h0000_0001, 32'(donePulses));
    $display("test cell size done");

    patternMode <= 4'h4;
    sendBytes(3'h2, 8'h20, 3);
    repeat (2) @(posedge clk);
    readCheck("pattern count", 8'h24, 32'h0000_0003);
    patternMatch <= 4'h4;
    @(posedge clk);
    patternMatch <= 4'h0;
    @(posedge clk);
    readCheck("pattern clear", 8'h24, 32'h0000_0000);
    sendBytes(3'h3, 8'h40, 20);
    repeat (4) @(posedge clk);
    readCheck("burst count", 8'h2C, 32'h0000_0014);
    // Channel 3 is not the checksum channel, so the sum must not move
    readCheck("sum untouched", 8'h04, 32'h0000_1233);
    $display("test progress done");
    completeRun();
  end
endmodule
`default_nettype wire
